// *** adi_top.sv ***
// Purpose: Register interface of the successive-approximation converter.
// Assumes: Avalon-MM slave with waitrequest, byte addresses, REF_CLK at 125 MHz.
// Notes:   Waitrequest idles high; each access is answered one cycle after it starts.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
module adi_top
   import adi_pkg::*;
#(
   parameter int CONV_TIME_NS = ADI_CONV_TIME_NS
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [ADI_AW-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [ADI_DW-1:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [ADI_DW-1:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic CONV_START_PIN,
   input wire logic [ADI_RES_W-1:0] ANALOG_CODE,
   output logic ADC_BUSY,
   output logic PORT0_LINE5_OUT,
   output logic PORT0_LINE5_OE,
   output logic IRQ,
   output logic [ADI_NEG_W-1:0] NEG_CHANNEL,
   output logic [ADI_MODE_W-1:0] INPUT_MODE,
   output logic [ADI_TRIM_W-1:0] GAIN_TRIM,
   output logic [ADI_TRIM_W-1:0] OFFSET_TRIM
);

   // Merge write data into an old word under the byte enables
   function automatic logic [31:0] be_merge(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0] be
   );
      logic [31:0] m;
      m = old_val;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // Only pins 0..15 and the internal reference are usable codes
   function automatic logic neg_code_ok(input logic [4:0] code);
      return (code <= ADI_NEG_LAST_PIN) || (code == ADI_NEG_INTREF);
   endfunction

   function automatic logic mode_ok(input logic [1:0] m);
      return (m == ADI_MODE_SINGLE) || (m == ADI_MODE_DIFF) || (m == ADI_MODE_PSEUDO);
   endfunction

   // Full-word match; every register owns one aligned word
   function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] off);
      return a == off;
   endfunction

   // Sticky flag update: a set in the same edge beats the clear
   function automatic logic sticky_next(input logic set, input logic clr, input logic cur);
      return set | (cur & ~clr);
   endfunction

   // Bus handshake state
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic acc;
   logic req;
   logic wr_acc;
   logic rd_acc;
   logic sel_ctrl;
   logic sel_neg;
   logic sel_res;
   logic sel_irst;
   logic sel_gn;
   logic sel_of;
   logic sel_ista;
   logic sel_imsk;
   logic ista_clr;
   logic imsk_wr;

   // Register contents
   logic pinen_reg;
   logic exten_reg;
   logic [1:0] mode_reg;
   logic [4:0] neg_reg;
   logic ready_reg;
   logic [9:0] gain_reg;
   logic [9:0] offs_reg;
   logic ista_reg;
   logic imsk_reg;
   logic irq_reg;
   logic pin_out_reg;

   // Synchronisers for pins
   logic ext_s1_reg;
   logic ext_s2_reg;
   logic ext_prev_reg;
   logic [11:0] code_s1_reg;
   logic [11:0] code_s2_reg;

   // Sequencer links
   logic soft_rst;
   logic start_sw;
   logic start_ext;
   logic seq_busy;
   logic seq_done;
   logic [11:0] seq_result;
   logic [31:0] ctrl_word;
   logic [31:0] neg_wr;
   logic [31:0] ctrl_wr;
   logic [31:0] gn_wr;
   logic [31:0] of_wr;
   logic [31:0] rd_mux;

   assign req = AVS_READ | AVS_WRITE;
   assign acc = req & ~wait_reg;
   assign wr_acc = acc & AVS_WRITE;
   assign rd_acc = acc & AVS_READ;

   // Register selects, decoded once for every writer
   assign sel_ctrl = addr_hit(AVS_ADDRESS, ADI_OFF_CTRL);
   assign sel_neg = addr_hit(AVS_ADDRESS, ADI_OFF_NEG);
   assign sel_res = addr_hit(AVS_ADDRESS, ADI_OFF_RES);
   assign sel_irst = addr_hit(AVS_ADDRESS, ADI_OFF_IRST);
   assign sel_gn = addr_hit(AVS_ADDRESS, ADI_OFF_GN);
   assign sel_of = addr_hit(AVS_ADDRESS, ADI_OFF_OF);
   assign sel_ista = addr_hit(AVS_ADDRESS, ADI_OFF_ISTA);
   assign sel_imsk = addr_hit(AVS_ADDRESS, ADI_OFF_IMSK);
   assign ista_clr = wr_acc && sel_ista && AVS_BYTEENABLE[0] && AVS_WRITEDATA[ADI_IRQ_DONE];
   assign imsk_wr = wr_acc && sel_imsk && AVS_BYTEENABLE[0];

   assign soft_rst = wr_acc && sel_irst;

   assign ctrl_word = {27'h0000000, exten_reg, mode_reg, pinen_reg, 1'b0};
   assign ctrl_wr = be_merge(ctrl_word, AVS_WRITEDATA, AVS_BYTEENABLE);
   assign neg_wr = be_merge({27'h0000000, neg_reg}, AVS_WRITEDATA, AVS_BYTEENABLE);
   assign gn_wr = be_merge({22'h000000, gain_reg}, AVS_WRITEDATA, AVS_BYTEENABLE);
   assign of_wr = be_merge({22'h000000, offs_reg}, AVS_WRITEDATA, AVS_BYTEENABLE);

   // Start strobe is self-clearing; it never stores
   assign start_sw = wr_acc && sel_ctrl && AVS_BYTEENABLE[0]
                     && AVS_WRITEDATA[ADI_CTRL_START];
   assign start_ext = exten_reg & ext_s2_reg & ~ext_prev_reg;

   adi_conv_seq #(
      .CONV_TIME_NS(CONV_TIME_NS)
   ) u_seq (
      .clk(REF_CLK),
      .rst(RST),
      .clr(soft_rst),
      .start(start_sw | start_ext),
      .sample(code_s2_reg),
      .busy(seq_busy),
      .done(seq_done),
      .result(seq_result)
   );

   // Start pin: two stages, then an edge detector idling low like the pin
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         ext_s1_reg <= CONV_START_PIN;
         ext_s2_reg <= ext_s1_reg;
         ext_prev_reg <= ext_s2_reg;
      end
   end

   // Code bus is held by the core over a conversion, so its bits settle together
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         code_s1_reg <= ADI_RES_RST;
         code_s2_reg <= ADI_RES_RST;
      end else begin
         code_s1_reg <= ANALOG_CODE;
         code_s2_reg <= code_s1_reg;
      end
   end

   // Read multiplexer
   always_comb begin
      rd_mux = ADI_ZERO;
      case (AVS_ADDRESS)
         ADI_OFF_CTRL: rd_mux = ctrl_word;
         ADI_OFF_NEG: rd_mux = {27'h0000000, neg_reg};
         ADI_OFF_STA: rd_mux = {31'h00000000, ready_reg};
         ADI_OFF_RES: rd_mux = {20'h00000, seq_result};
         ADI_OFF_GN: rd_mux = {22'h000000, gain_reg};
         ADI_OFF_OF: rd_mux = {22'h000000, offs_reg};
         ADI_OFF_ISTA: rd_mux = {31'h00000000, ista_reg};
         ADI_OFF_IMSK: rd_mux = {31'h00000000, imsk_reg};
         default: rd_mux = ADI_ZERO;
      endcase
   end

   // Waitrequest idles high; drops for one cycle with data ready
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         wait_reg <= 1'b1;
         rdata_reg <= ADI_ZERO;
      end else if (acc) begin
         wait_reg <= 1'b1;
      end else if (req) begin
         wait_reg <= 1'b0;
         // Captured one edge early; a result landing later sets the flag again
         rdata_reg <= rd_mux;
      end
   end

   // Control: busy pin enable, external start enable, input mode
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         pinen_reg <= 1'b0;
         exten_reg <= 1'b0;
         mode_reg <= ADI_MODE_SINGLE;
      end else if (soft_rst) begin
         pinen_reg <= 1'b0;
         exten_reg <= 1'b0;
         mode_reg <= ADI_MODE_SINGLE;
      end else if (wr_acc && sel_ctrl) begin
         pinen_reg <= ctrl_wr[ADI_CTRL_PINEN];
         exten_reg <= ctrl_wr[ADI_CTRL_EXTEN];
         // Reserved mode code keeps the previous mode
         if (mode_ok(ctrl_wr[ADI_CTRL_MODE_MSB:ADI_CTRL_MODE_LSB])) begin
            mode_reg <= ctrl_wr[ADI_CTRL_MODE_MSB:ADI_CTRL_MODE_LSB];
         end
      end
   end

   // Negative channel select
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         neg_reg <= ADI_NEG_RST;
      end else if (soft_rst) begin
         neg_reg <= ADI_NEG_RST;
      end else if (wr_acc && sel_neg) begin
         // Reserved codes are dropped so the mux never sees them
         if (neg_code_ok(neg_wr[4:0])) begin
            neg_reg <= neg_wr[4:0];
         end
      end
   end

   // Ready flag: a completing conversion wins over the read clear
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ready_reg <= 1'b0;
      end else if (soft_rst) begin
         ready_reg <= 1'b0;
      end else if (seq_done) begin
         ready_reg <= 1'b1;
      end else if (rd_acc && sel_res) begin
         ready_reg <= 1'b0;
      end
   end

   // Calibration trims
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         gain_reg <= ADI_GN_RST;
         offs_reg <= ADI_OF_RST;
      end else if (soft_rst) begin
         gain_reg <= ADI_GN_RST;
         offs_reg <= ADI_OF_RST;
      end else if (wr_acc && sel_gn) begin
         gain_reg <= gn_wr[ADI_TRIM_W-1:0];
      end else if (wr_acc && sel_of) begin
         offs_reg <= of_wr[ADI_TRIM_W-1:0];
      end
   end

   // Sticky interrupt status, write one to clear, set wins
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ista_reg <= 1'b0;
      end else if (soft_rst) begin
         ista_reg <= 1'b0;
      end else if (seq_done) begin
         ista_reg <= 1'b1;
      end else if (ista_clr) begin
         ista_reg <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         imsk_reg <= 1'b0;
      end else if (soft_rst) begin
         imsk_reg <= 1'b0;
      end else if (imsk_wr) begin
         imsk_reg <= AVS_WRITEDATA[ADI_IRQ_DONE];
      end
   end

   // Request follows the next status and mask, so it rises with the ready flag
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         irq_reg <= 1'b0;
      end else if (soft_rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= sticky_next(seq_done, ista_clr, ista_reg)
                    & (imsk_wr ? AVS_WRITEDATA[ADI_IRQ_DONE] : imsk_reg);
      end
   end

   // Pin copy of busy lags the busy output by one cycle
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         pin_out_reg <= 1'b0;
      end else begin
         pin_out_reg <= pinen_reg & seq_busy;
      end
   end

   assign AVS_READDATA = rdata_reg;
   assign AVS_WAITREQUEST = wait_reg;
   assign ADC_BUSY = seq_busy;
   assign PORT0_LINE5_OUT = pin_out_reg;
   assign PORT0_LINE5_OE = pinen_reg;
   assign IRQ = irq_reg;
   assign NEG_CHANNEL = neg_reg;
   assign INPUT_MODE = mode_reg;
   assign GAIN_TRIM = gain_reg;
   assign OFFSET_TRIM = offs_reg;

endmodule

// *** adi_pkg.sv ***
// Purpose: Shared constants and types of the converter digital interface.
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register.
// Notes:   Offsets are full byte addresses as seen by the bus master.
package adi_pkg;
   localparam int ADI_DW = 32;
   localparam int ADI_AW = 32;
   localparam int ADI_RES_W = 12;
   localparam int ADI_TRIM_W = 10;
   localparam int ADI_NEG_W = 5;
   localparam int ADI_MODE_W = 2;

   // Register byte addresses
   localparam logic [31:0] ADI_OFF_CTRL = 32'hffff0500;
   localparam logic [31:0] ADI_OFF_NEG = 32'hffff0508;
   localparam logic [31:0] ADI_OFF_STA = 32'hffff050c;
   localparam logic [31:0] ADI_OFF_RES = 32'hffff0510;
   localparam logic [31:0] ADI_OFF_IRST = 32'hffff0514;
   localparam logic [31:0] ADI_OFF_GN = 32'hffff0530;
   localparam logic [31:0] ADI_OFF_OF = 32'hffff0534;
   localparam logic [31:0] ADI_OFF_ISTA = 32'hffff0540;
   localparam logic [31:0] ADI_OFF_IMSK = 32'hffff0544;

   // Reset values
   localparam logic [9:0] ADI_GN_RST = 10'h200;
   localparam logic [9:0] ADI_OF_RST = 10'h200;
   localparam logic [4:0] ADI_NEG_RST = 5'h00;
   localparam logic [11:0] ADI_RES_RST = 12'h000;
   localparam logic [31:0] ADI_ZERO = 32'h00000000;

   // Control register fields
   localparam int ADI_CTRL_START = 0;
   localparam int ADI_CTRL_PINEN = 1;
   localparam int ADI_CTRL_MODE_LSB = 2;
   localparam int ADI_CTRL_MODE_MSB = 3;
   localparam int ADI_CTRL_EXTEN = 4;

   // Status, interrupt and channel fields
   localparam int ADI_STA_READY = 0;
   localparam int ADI_IRQ_DONE = 0;
   localparam logic [4:0] ADI_NEG_LAST_PIN = 5'h0f;
   localparam logic [4:0] ADI_NEG_INTREF = 5'h10;

   typedef enum logic [1:0] {
      ADI_MODE_SINGLE = 2'h0,
      ADI_MODE_DIFF = 2'h1,
      ADI_MODE_PSEUDO = 2'h2
   } adi_mode_t;

   typedef enum logic [1:0] {
      ADI_SEQ_IDLE = 2'h0,
      ADI_SEQ_CONV = 2'h1,
      ADI_SEQ_DONE = 2'h3
   } adi_seq_state_t;

   // Timing
   localparam int ADI_CLK_PERIOD_PS = 8000;
   localparam int ADI_CONV_TIME_NS = 1000;
   localparam int ADI_PS_PER_NS = 1000;
endpackage

// *** adi_conv_seq.sv ***
// Purpose: Conversion sequencer: busy window, end-of-conversion pulse, result capture.
// Assumes: Sampled code is already synchronised and stable at the end of a conversion.
// Notes:   Clear aborts a running conversion and empties the result.
`timescale 1ns/1ps
module adi_conv_seq
   import adi_pkg::*;
#(
   parameter int CONV_TIME_NS = ADI_CONV_TIME_NS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clr,
   input wire logic start,
   input wire logic [ADI_RES_W-1:0] sample,
   output logic busy,
   output logic done,
   output logic [ADI_RES_W-1:0] result
);
   // Least time, rounded up to whole cycles
   localparam int CONV_CYC_RAW =
      (CONV_TIME_NS * ADI_PS_PER_NS + ADI_CLK_PERIOD_PS - 1) / ADI_CLK_PERIOD_PS;
   localparam int CONV_CYC = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
   localparam int CW = $clog2(CONV_CYC + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(CONV_CYC - 1);
   localparam logic [CW-1:0] CNT_ZERO = '0;
   localparam logic [CW-1:0] CNT_ONE = CW'(1);

   adi_seq_state_t state_reg;
   logic [CW-1:0] cnt_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ADI_SEQ_IDLE;
         cnt_reg <= '0;
      end else if (clr) begin
         state_reg <= ADI_SEQ_IDLE;
         cnt_reg <= '0;
      end else begin
         case (state_reg)
            ADI_SEQ_IDLE: begin
               cnt_reg <= CNT_ZERO;
               if (start) begin
                  state_reg <= ADI_SEQ_CONV;
               end
            end
            ADI_SEQ_CONV: begin
               cnt_reg <= cnt_reg + CNT_ONE;
               if (cnt_reg == CNT_LAST) begin
                  state_reg <= ADI_SEQ_DONE;
               end
            end
            ADI_SEQ_DONE: begin
               state_reg <= ADI_SEQ_IDLE;
            end
            default: begin
               state_reg <= ADI_SEQ_IDLE;
            end
         endcase
      end
   end

   // Busy high for the whole conversion, low in the cycle it ends
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
      end else if (clr) begin
         busy <= 1'b0;
      end else if (state_reg == ADI_SEQ_IDLE && start) begin
         busy <= 1'b1;
      end else if (state_reg == ADI_SEQ_CONV && cnt_reg == CNT_LAST) begin
         busy <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done <= 1'b0;
         result <= ADI_RES_RST;
      end else if (clr) begin
         done <= 1'b0;
         result <= ADI_RES_RST;
      end else begin
         done <= (state_reg == ADI_SEQ_CONV && cnt_reg == CNT_LAST);
         if (state_reg == ADI_SEQ_CONV && cnt_reg == CNT_LAST) begin
            result <= sample;
         end
      end
   end
endmodule

// *** adi_chk.sv ***
// Purpose: Port checks of the converter register interface.
// Assumes: One clock, RST asynchronous and active high.
// Notes:   Bound to the top module after the end of this module.
`timescale 1ns/1ps
module adi_chk
   import adi_pkg::*;
#(
   parameter int CONV_TIME_NS = ADI_CONV_TIME_NS
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [ADI_AW-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [ADI_DW-1:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [ADI_DW-1:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic ADC_BUSY,
   input wire logic PORT0_LINE5_OUT,
   input wire logic PORT0_LINE5_OE,
   input wire logic IRQ,
   input wire logic [ADI_NEG_W-1:0] NEG_CHANNEL,
   input wire logic [ADI_MODE_W-1:0] INPUT_MODE,
   input wire logic [ADI_TRIM_W-1:0] GAIN_TRIM,
   input wire logic [ADI_TRIM_W-1:0] OFFSET_TRIM
);
   localparam int CONV_CYC = (CONV_TIME_NS * ADI_PS_PER_NS + ADI_CLK_PERIOD_PS - 1)
      / ADI_CLK_PERIOD_PS;
   logic wr_acc;
   logic rd_acc;
   logic [7:0] busy_cnt;
   assign wr_acc = AVS_WRITE && !AVS_WAITREQUEST;
   assign rd_acc = AVS_READ && !AVS_WAITREQUEST;
   // Busy cycles seen so far, cleared while idle
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         busy_cnt <= 8'h00;
      end else begin
         busy_cnt <= ADC_BUSY ? busy_cnt + 8'h01 : 8'h00;
      end
   end
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   busy_length_a: assert property (
      $fell(ADC_BUSY) && !$past(wr_acc && AVS_ADDRESS == ADI_OFF_IRST)
      |-> busy_cnt == 8'(CONV_CYC)) else $error("busy window length wrong");
   start_busy_a: assert property (
      wr_acc && AVS_ADDRESS == ADI_OFF_CTRL && AVS_BYTEENABLE[0] && AVS_WRITEDATA[0]
      && !ADC_BUSY && !$past(ADC_BUSY) && !$past(ADC_BUSY, 2) |=> ADC_BUSY)
      else $error("start did not raise busy");
   irq_cause_a: assert property (
      $rose(IRQ) |-> ($past(ADC_BUSY, 2) && !$past(ADC_BUSY))
      || $past(wr_acc && AVS_ADDRESS == ADI_OFF_IMSK)) else $error("irq without cause");
   pin_follow_a: assert property (
      PORT0_LINE5_OUT == ($past(ADC_BUSY) && $past(PORT0_LINE5_OE)))
      else $error("port line does not follow gated busy");
   neg_select_a: assert property (
      wr_acc && AVS_ADDRESS == ADI_OFF_NEG && AVS_BYTEENABLE[0] |=> NEG_CHANNEL ==
      (($past(AVS_WRITEDATA[4:0]) > ADI_NEG_INTREF) ? $past(NEG_CHANNEL)
      : $past(AVS_WRITEDATA[4:0]))) else $error("channel select wrong");
   mode_select_a: assert property (
      wr_acc && AVS_ADDRESS == ADI_OFF_CTRL && AVS_BYTEENABLE[0] |=> INPUT_MODE ==
      (($past(AVS_WRITEDATA[3:2]) == 2'h3) ? $past(INPUT_MODE)
      : $past(AVS_WRITEDATA[3:2]))) else $error("input mode wrong");
   gain_write_a: assert property (
      wr_acc && AVS_ADDRESS == ADI_OFF_GN && AVS_BYTEENABLE == 4'hf
      |=> GAIN_TRIM == $past(AVS_WRITEDATA[9:0])) else $error("gain write lost");
   trim_hold_a: assert property (
      $changed(GAIN_TRIM) || $changed(OFFSET_TRIM) |-> $past(wr_acc && (AVS_ADDRESS ==
      ADI_OFF_GN || AVS_ADDRESS == ADI_OFF_OF || AVS_ADDRESS == ADI_OFF_IRST)))
      else $error("trim changed without write");
   soft_reset_a: assert property (
      wr_acc && AVS_ADDRESS == ADI_OFF_IRST |=> GAIN_TRIM == ADI_GN_RST
      && OFFSET_TRIM == ADI_OF_RST && NEG_CHANNEL == ADI_NEG_RST && INPUT_MODE == 2'h0
      && !ADC_BUSY ##1 !IRQ && !PORT0_LINE5_OE) else $error("soft reset incomplete");
   status_zero_a: assert property (
      rd_acc && AVS_ADDRESS == ADI_OFF_STA |-> AVS_READDATA[31:1] == 31'h0)
      else $error("status upper bits not zero");
   result_width_a: assert property (
      rd_acc && AVS_ADDRESS == ADI_OFF_RES |-> AVS_READDATA[31:12] == 20'h0)
      else $error("result upper bits not zero");
endmodule

bind adi_top adi_chk #(.CONV_TIME_NS(CONV_TIME_NS)) i_chk (
   .REF_CLK(REF_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .ADC_BUSY(ADC_BUSY),
   .PORT0_LINE5_OUT(PORT0_LINE5_OUT), .PORT0_LINE5_OE(PORT0_LINE5_OE), .IRQ(IRQ),
   .NEG_CHANNEL(NEG_CHANNEL), .INPUT_MODE(INPUT_MODE), .GAIN_TRIM(GAIN_TRIM),
   .OFFSET_TRIM(OFFSET_TRIM));

// *** testbench.sv ***
// Purpose: Self-checking bench of the converter register interface.
// Assumes: Conversion shortened to 10 cycles through CONV_TIME_NS.
// Notes:   Bus tasks leave idle cycles between accesses.
`timescale 1ns/1ps
module testbench
   import adi_pkg::*;
;
   localparam int CONV_NS = 80;
   localparam int CONV_CYC = (CONV_NS * ADI_PS_PER_NS + ADI_CLK_PERIOD_PS - 1)
      / ADI_CLK_PERIOD_PS;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic pin = 1'b0;
   logic [3:0] be = 4'hf;
   logic [11:0] code = 12'h000;
   logic [31:0] addr = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic waitreq, busy, p5_out, p5_oe, irq;
   logic [4:0] neg;
   logic [1:0] mode;
   logic [9:0] gain, offs;
   integer seed = 53;
   int fails = 0;
   int checks_done = 0;
   int run = 0;
   int last_len = 0;
   always #4 clk = ~clk;
   adi_top #(.CONV_TIME_NS(CONV_NS)) i_dut (
      .REF_CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(waitreq), .CONV_START_PIN(pin), .ANALOG_CODE(code),
      .ADC_BUSY(busy), .PORT0_LINE5_OUT(p5_out), .PORT0_LINE5_OE(p5_oe), .IRQ(irq),
      .NEG_CHANNEL(neg), .INPUT_MODE(mode), .GAIN_TRIM(gain), .OFFSET_TRIM(offs));
   // Length of the last busy window, in cycles
   always @(posedge clk) begin
      if (busy === 1'b1) begin
         run <= run + 1;
      end else if (run != 0) begin
         last_len <= run;
         run <= 0;
      end
   end
   function automatic logic [4:0] exp_neg(input logic [4:0] old, input logic [4:0] c);
      return (c > ADI_NEG_INTREF) ? old : c;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic guard(input int k, input int lim);
      if (k >= lim) begin
         fails++;
         $display("unexpected at %0t: wait ran out", $time);
         finish_test();
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int k;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (waitreq !== 1'b0 && k < 20);
      guard(k, 20);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // Two extra edges so registered outputs have settled
   task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      repeat (2) @(posedge clk);
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask
   task automatic wait_conv();
      int k;
      k = 0;
      while (busy !== 1'b1 && k < 40) begin
         @(posedge clk);
         k++;
      end
      guard(k, 40);
      k = 0;
      while (busy !== 1'b0 && k < 200) begin
         @(posedge clk);
         k++;
      end
      guard(k, 200);
      repeat (3) @(posedge clk);
   endtask
   initial begin
      logic [31:0] g;
      logic [4:0] c_prev;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd_chk(ADI_OFF_GN, 32'h200);
      rd_chk(ADI_OFF_OF, 32'h200);
      rd_chk(ADI_OFF_RES, ADI_ZERO);
      rd_chk(ADI_OFF_STA, ADI_ZERO);
      rd_chk(32'hffff0520, ADI_ZERO);
      for (int i = 0; i < 8; i++) begin
         g = $random(seed);
         wr_reg(i[0] ? ADI_OFF_OF : ADI_OFF_GN, g);
         rd_chk(i[0] ? ADI_OFF_OF : ADI_OFF_GN, g & 32'h3ff);
         check(32'(i[0] ? offs : gain), g & 32'h3ff);
      end
      wr_reg(ADI_OFF_GN, 32'h000000a5);
      be <= 4'h2;
      wr_reg(ADI_OFF_GN, 32'hffffffff);
      be <= 4'hf;
      rd_chk(ADI_OFF_GN, 32'h3a5);
      wr_reg(ADI_OFF_RES, 32'hffffffff);
      rd_chk(ADI_OFF_RES, ADI_ZERO);
      wr_reg(ADI_OFF_STA, 32'hffffffff);
      rd_chk(ADI_OFF_STA, ADI_ZERO);
      c_prev = 5'h00;
      for (int c = 0; c < 32; c++) begin
         g = $random(seed);
         wr_reg(ADI_OFF_NEG, {g[31:5], 5'(c)});
         c_prev = exp_neg(c_prev, 5'(c));
         rd_chk(ADI_OFF_NEG, {27'h0, c_prev});
         check(32'(neg), 32'(c_prev));
      end
      for (int m = 0; m < 4; m++) begin
         wr_reg(ADI_OFF_CTRL, 32'(m) << 2);
         check(32'(mode), (m == 3) ? 32'h2 : 32'(m));
      end
      wr_reg(ADI_OFF_IMSK, 32'h1);
      code <= 12'($random(seed));
      wr_reg(ADI_OFF_CTRL, 32'h3);
      check(32'({p5_oe, p5_out, busy}), 32'h7);
      wr_reg(ADI_OFF_CTRL, 32'h3);
      wait_conv();
      check(32'(last_len), 32'(CONV_CYC));
      check(32'(irq), 32'h1);
      rd_chk(ADI_OFF_STA, 32'h1);
      rd_chk(ADI_OFF_RES, {20'h0, code});
      rd_chk(ADI_OFF_STA, ADI_ZERO);
      wr_reg(ADI_OFF_ISTA, 32'h1);
      check(32'(irq), 32'h0);
      wr_reg(ADI_OFF_IMSK, 32'h0);
      wr_reg(ADI_OFF_CTRL, 32'h1);
      check(32'({p5_oe, p5_out, busy}), 32'h1);
      wait_conv();
      check(32'(irq), 32'h0);
      rd_chk(ADI_OFF_STA, 32'h1);
      wr_reg(ADI_OFF_IMSK, 32'h1);
      check(32'(irq), 32'h1);
      wr_reg(ADI_OFF_ISTA, 32'h1);
      wr_reg(ADI_OFF_CTRL, 32'h10);
      @(posedge clk);
      pin <= 1'b1;
      wait_conv();
      pin <= 1'b0;
      check(32'({irq, last_len[7:0]}), 32'(CONV_CYC) | 32'h100);
      wr_reg(ADI_OFF_GN, 32'h155);
      wr_reg(ADI_OFF_CTRL, 32'h6);
      wr_reg(ADI_OFF_CTRL, 32'h7);
      wr_reg(ADI_OFF_IRST, $random(seed));
      check(32'({p5_oe, busy, irq, mode}), 32'h0);
      rd_chk(ADI_OFF_GN, 32'h200);
      rd_chk(ADI_OFF_STA, ADI_ZERO);
      finish_test();
   end
endmodule
